// ---- cantrx_top.sv ----
// Transceiver mode control and digital bit path.
// Assumes all inputs synchronous to CLK; bus levels are digital
// (BUS_RX_LEVEL high = recessive); mode set by a one-cycle command.
`timescale 1ns/100ps
`default_nettype none
module cantrx_top
  import cantrx_pkg::*;
#(
  parameter int EN_CYC = CANTRX_EN_CYC,
  parameter int WAKE1_CYC = CANTRX_WAKE1_CYC,
  parameter int WAKE2_CYC = CANTRX_WAKE2_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic MODE_WR,
  input wire logic [1:0] MODE_CODE,
  input wire logic [2:0] CHIP_MODE,
  input wire logic BUS_TX_INPUT,
  input wire logic BUS_RX_LEVEL,
  input wire logic SAMPLE_READY,
  output logic BUS_DRIVE_DOM,
  output logic BUS_RX_OUTPUT,
  output logic [1:0] MODE_STATUS,
  output logic WAKE_EVENT,
  output logic SAMPLE_VALID,
  output logic SAMPLE_DATA
);
  cantrx_mode_e mode_reg, mode_next; // Transceiver mode
  cantrx_wstate_e ws_reg, ws_next; // Wake detector state
  logic [CANTRX_CNT_W-1:0] en_cnt_reg, en_cnt_next; // Enable delay
  logic [CANTRX_CNT_W-1:0] ph_cnt_reg, ph_cnt_next; // Phase length
  logic armed_reg, armed_next; // Early low seen; wait for high
  logic woke_reg, woke_next; // Wake latched in current mode
  logic drv_reg, drv_next; // Dominant drive
  logic rxo_reg, rxo_next; // Receive output
  logic wev_reg, wev_next; // Wake pulse
  logic sv_reg, sv_next; // Sample valid out
  logic sd_reg, sd_next; // Sample data out
  logic prev_rx_reg, prev_rx_next; // Last bus level
  logic mode_ok; // Requested mode allowed now
  logic en_done; // Enabling delay elapsed
  logic ph_long, ph_short; // Phase within filter bounds
  logic [CANTRX_CNT_W-1:0] w1, w2, en_len;
  cantrx_fifo_if #(.W(CANTRX_FIFO_W)) fq ();

  assign w1 = CANTRX_CNT_W'(WAKE1_CYC);
  assign w2 = CANTRX_CNT_W'(WAKE2_CYC);
  assign en_len = CANTRX_CNT_W'(EN_CYC);
  assign en_done = (en_cnt_reg == CANTRX_CNT_ZERO);
  assign ph_long = (ph_cnt_reg > w1);
  assign ph_short = (ph_cnt_reg < w2);

  // Mode permission per chip mode
  always_comb
  begin
    unique case (cantrx_mode_e'(MODE_CODE))
      CANTRX_OFF: mode_ok = 1'b1; // [RULE2]
      CANTRX_NORMAL: mode_ok = (CHIP_MODE == CANTRX_CHIP_NORMAL); // [RULE3]
      CANTRX_RXONLY: mode_ok = (CHIP_MODE == CANTRX_CHIP_NORMAL) ||
        (CHIP_MODE == CANTRX_CHIP_STOP); // [RULE11]
      CANTRX_WAKE: mode_ok = (CHIP_MODE != CANTRX_CHIP_FAILSAFE) ||
        1'b1; // [RULE10]
    endcase
  end

  // Mode, enabling delay and transmit path
  always_comb
  begin
    mode_next = mode_reg;
    en_cnt_next = en_cnt_reg;
    armed_next = armed_reg;
    drv_next = 1'b0;
    if (CHIP_MODE == CANTRX_CHIP_FAILSAFE)
      mode_next = CANTRX_WAKE; // Fail-safe forces wake watch
    else if (MODE_WR && mode_ok)
      mode_next = cantrx_mode_e'(MODE_CODE); // [RULE3]
    if (mode_next == CANTRX_NORMAL && mode_reg != CANTRX_NORMAL)
    begin
      en_cnt_next = en_len; // Start delay on entry [RULE15]
      armed_next = 1'b0;
    end
    else if (mode_reg == CANTRX_NORMAL)
    begin
      if (!en_done)
      begin
        en_cnt_next = en_cnt_reg - CANTRX_CNT_ONE;
        if (!BUS_TX_INPUT)
          armed_next = 1'b1; // Early low seen [RULE6]
      end
      else if (BUS_TX_INPUT)
        armed_next = 1'b0; // High after expiry releases [RULE15]
      // Dominant only after delay and no stale low [RULE4]
      drv_next = en_done && !armed_reg && !BUS_TX_INPUT &&
        (mode_next == CANTRX_NORMAL); // [RULE6]
    end
  end

  // Wake pattern detector over the bus level
  always_comb
  begin
    ws_next = ws_reg;
    ph_cnt_next = ph_cnt_reg;
    wev_next = 1'b0;
    woke_next = woke_reg;
    prev_rx_next = BUS_RX_LEVEL;
    if (ph_cnt_reg != CANTRX_CNT_MAX)
      ph_cnt_next = ph_cnt_reg + CANTRX_CNT_ONE;
    if (BUS_RX_LEVEL != prev_rx_reg)
      ph_cnt_next = CANTRX_CNT_ONE; // New phase begins
    // Rearm on any mode change
    if (mode_next != mode_reg)
      woke_next = 1'b0; // [RULE13]
    if (mode_reg != CANTRX_WAKE || woke_reg)
      ws_next = CANTRX_W_IDLE; // Off ignores the bus [RULE2]
    else
    begin
      unique case (ws_reg)
        CANTRX_W_IDLE:
          if (!BUS_RX_LEVEL && prev_rx_reg)
            ws_next = CANTRX_W_DOM1;
        CANTRX_W_DOM1:
          if (BUS_RX_LEVEL) // Dominant ended [RULE12]
            ws_next = (ph_long && ph_short) ? CANTRX_W_REC
              : CANTRX_W_IDLE;
        CANTRX_W_REC:
          if (!BUS_RX_LEVEL)
            ws_next = (ph_long && ph_short) ? CANTRX_W_DOM2
              : CANTRX_W_IDLE;
          else if (!ph_short)
            ws_next = CANTRX_W_IDLE;
        CANTRX_W_DOM2:
          if (BUS_RX_LEVEL)
            ws_next = CANTRX_W_IDLE;
          else if (ph_cnt_reg == w1 + CANTRX_CNT_ONE)
          begin
            ws_next = CANTRX_W_IDLE;
            wev_next = 1'b1; // [RULE9]
            woke_next = 1'b1; // Mode code stays 01 [RULE14]
          end
        default:
          ws_next = CANTRX_W_IDLE;
      endcase
    end
  end

  // Receive output and sample capture
  always_comb
  begin
    unique case (mode_reg)
      CANTRX_NORMAL, CANTRX_RXONLY:
        rxo_next = BUS_RX_LEVEL; // [RULE7]
      CANTRX_WAKE:
        rxo_next = !(woke_reg || wev_next); // [RULE13]
      CANTRX_OFF:
        rxo_next = 1'b1; // No reception [RULE1]
    endcase
    // Bit stream to FIFO; one-cycle sampling keeps 5 Mbaud [RULE8]
    fq.in_valid = (mode_reg == CANTRX_NORMAL) ||
      (mode_reg == CANTRX_RXONLY);
    fq.in_data = BUS_RX_LEVEL;
    fq.out_ready = !sv_reg || SAMPLE_READY;
    sv_next = sv_reg;
    sd_next = sd_reg;
    if (fq.out_ready)
    begin
      sv_next = fq.out_valid;
      sd_next = fq.out_valid ? fq.out_data : sd_reg;
    end
  end

  // Register all state
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      mode_reg <= CANTRX_OFF; // [RULE1]
      ws_reg <= CANTRX_W_IDLE;
      en_cnt_reg <= CANTRX_CNT_ZERO;
      ph_cnt_reg <= CANTRX_CNT_ZERO;
      armed_reg <= 1'b0;
      woke_reg <= 1'b0;
      drv_reg <= 1'b0;
      rxo_reg <= 1'b1;
      wev_reg <= 1'b0;
      sv_reg <= 1'b0;
      sd_reg <= 1'b1;
      prev_rx_reg <= 1'b1;
    end
    else if (CE)
    begin
      mode_reg <= mode_next;
      ws_reg <= ws_next;
      en_cnt_reg <= en_cnt_next;
      ph_cnt_reg <= ph_cnt_next;
      armed_reg <= armed_next;
      woke_reg <= woke_next;
      drv_reg <= drv_next;
      rxo_reg <= rxo_next;
      wev_reg <= wev_next;
      sv_reg <= sv_next;
      sd_reg <= sd_next;
      prev_rx_reg <= prev_rx_next;
    end
  end

  // Sample FIFO; the sample output may stall on SAMPLE_READY, new samples dropped while full
  cantrx_fifo #(.W(CANTRX_FIFO_W), .D(CANTRX_FIFO_D)) u_fifo (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .CE(CE),
    .f(fq.fifo)
  );

  assign BUS_DRIVE_DOM = drv_reg;
  assign BUS_RX_OUTPUT = rxo_reg;
  assign MODE_STATUS = mode_reg; // [RULE14]
  assign WAKE_EVENT = wev_reg;
  assign SAMPLE_VALID = sv_reg;
  assign SAMPLE_DATA = sd_reg;
endmodule // cantrx_top
`default_nettype wire

// ---- cantrx_pkg.sv ----
// Constants and types for the bus transceiver mode control block.
// Assumes a 40 MHz system clock; no registers reached by software.
//
// Overview of operation
// [RULE1] Power-up mode is off; no traffic.
// [RULE2] Off always selectable; bus wake ignored. Code forces wake-capable while chip is fail-safe.
// [RULE3] Normal mode only by command, chip normal.
// [RULE4] Normal: low input gives dominant, high recessive.
// [RULE5] Controller holds input high through enabling delay.
// [RULE6] Early low never reaches bus; next dominant does.
// [RULE7] Receive output shows the bus level.
// [RULE8] Rates to 5 Mbaud, flexible-rate frames tolerated.
// [RULE9] Wake-capable: valid wake pattern signals wake-up.
// [RULE10] Receive-only diagnostics and wake-capable low power.
// [RULE11] Receive-only: driver off, chip normal or stop.
// [RULE12] Wake pattern: dominant, recessive, dominant, bounded.
// [RULE13] After wake, receive output low until mode change.
// [RULE14] Wake-capable code 01 stays after wake.
// [RULE15] Enable counter; early low blocked until high.
package cantrx_pkg;
  // Transceiver mode codes as held by the mode control field
  typedef enum logic [1:0] {
    CANTRX_OFF = 2'h0,
    CANTRX_WAKE = 2'h1,
    CANTRX_RXONLY = 2'h2,
    CANTRX_NORMAL = 2'h3
  } cantrx_mode_e;
  // Chip operating modes seen by the transceiver
  typedef enum logic [2:0] {
    CANTRX_CHIP_NORMAL = 3'h0,
    CANTRX_CHIP_STOP = 3'h1,
    CANTRX_CHIP_SLEEP = 3'h2,
    CANTRX_CHIP_RESTART = 3'h3,
    CANTRX_CHIP_FAILSAFE = 3'h4
  } cantrx_chip_e;
  // Wake pattern detector states, one-hot
  typedef enum logic [3:0] {
    CANTRX_W_IDLE = 4'h1,
    CANTRX_W_DOM1 = 4'h2,
    CANTRX_W_REC = 4'h4,
    CANTRX_W_DOM2 = 4'h8
  } cantrx_wstate_e;
  localparam int CANTRX_CLK_MHZ = 40;
  // Enabling delay and wake filter times, in ns
  localparam int CANTRX_T_EN_NS = 10000;
  localparam int CANTRX_T_WAKE1_NS = 500;
  localparam int CANTRX_T_WAKE2_NS = 1000000;
  // Least times round up, longest rounds down
  localparam int CANTRX_EN_CYC =
    (CANTRX_T_EN_NS * CANTRX_CLK_MHZ + 999) / 1000;
  localparam int CANTRX_WAKE1_CYC =
    (CANTRX_T_WAKE1_NS * CANTRX_CLK_MHZ + 999) / 1000;
  localparam int CANTRX_WAKE2_CYC =
    (CANTRX_T_WAKE2_NS * CANTRX_CLK_MHZ) / 1000;
  localparam int CANTRX_CNT_W = 16;
  localparam logic [CANTRX_CNT_W-1:0] CANTRX_CNT_ZERO = 16'h0000;
  localparam logic [CANTRX_CNT_W-1:0] CANTRX_CNT_ONE = 16'h0001;
  localparam logic [CANTRX_CNT_W-1:0] CANTRX_CNT_MAX = 16'hFFFF;
  // Captured receive-level FIFO shape
  localparam int CANTRX_FIFO_W = 1;
  localparam int CANTRX_FIFO_D = 16;
endpackage

// ---- cantrx_fifo_if.sv ----
// Interface joining the top module to its sample FIFO.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface cantrx_fifo_if #(parameter int W = 1);
  logic in_valid; // Source offers a word
  logic in_ready; // FIFO can take it
  logic [W-1:0] in_data; // Word in
  logic out_valid; // FIFO holds a word
  logic out_ready; // Sink takes it
  logic [W-1:0] out_data; // Word out
  modport fifo (input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ---- cantrx_fifo.sv ----
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous active-low reset and a freezing clock enable.
`timescale 1ns/100ps
`default_nettype none
module cantrx_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  cantrx_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH = (AW+1)'(D);
  logic [W-1:0] mem_reg [D]; // Storage
  logic [W-1:0] mem_next [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next; // Pointers
  logic [AW:0] cnt_reg, cnt_next; // Fill level
  logic push, pop;
  // Honest flags from the fill level
  assign f.in_ready = (cnt_reg != DEPTH);
  assign f.out_valid = (cnt_reg != '0);
  assign f.out_data = mem_reg[rp_reg];
  // Next-state computation
  always_comb
  begin
    push = f.in_valid & f.in_ready;
    pop = f.out_valid & f.out_ready;
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      mem_next[wp_reg] = f.in_data;
      wp_next = AW'((D-1) == int'(wp_reg) ? 0 : int'(wp_reg) + 1);
    end
    if (pop)
      rp_next = AW'((D-1) == int'(rp_reg) ? 0 : int'(rp_reg) + 1);
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end
  // Registers only
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      for (int i = 0; i < D; i++)
        mem_reg[i] <= '0;
    end
    else if (CE)
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end
endmodule // cantrx_fifo
`default_nettype wire

// ---- cantrx_assertions.sv ----
// Concurrent checks on the ports of the transceiver mode control block.
// Assumes binding to cantrx_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cantrx_assertions
  import cantrx_pkg::*;
#(
  parameter int EN_CYC = CANTRX_EN_CYC,
  parameter int WAKE1_CYC = CANTRX_WAKE1_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic MODE_WR,
  input wire logic [1:0] MODE_CODE,
  input wire logic [2:0] CHIP_MODE,
  input wire logic BUS_TX_INPUT,
  input wire logic BUS_RX_LEVEL,
  input wire logic BUS_DRIVE_DOM,
  input wire logic BUS_RX_OUTPUT,
  input wire logic [1:0] MODE_STATUS,
  input wire logic WAKE_EVENT
);
  logic [15:0] en_reg, en_next; // Cycles spent in normal mode
  logic [15:0] dom_reg, dom_next; // Run of dominant samples
  // Helper counters; wrap is harmless over a short run
  always_comb
  begin
    en_next = (MODE_STATUS == 2'h3) ? en_reg + 16'h0001 : 16'h0000;
    dom_next = BUS_RX_LEVEL ? 16'h0000 : dom_reg + 16'h0001;
  end
  // Register the helpers, cleared in reset
  always_ff @(posedge CLK)
  begin
    en_reg <= RESET_N ? en_next : 16'h0000;
    dom_reg <= RESET_N ? dom_next : 16'h0000;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_RESET_OFF: assert property (
    $rose(RESET_N) |-> MODE_STATUS == 2'h0 && !BUS_DRIVE_DOM
    && BUS_RX_OUTPUT)
    else $error("not off after reset");
  AST_OFF_QUIET: assert property (
    MODE_STATUS == 2'h0 |-> !WAKE_EVENT)
    else $error("wake seen while off");
  AST_NORMAL_TAKEN: assert property (
    CE && MODE_WR && MODE_CODE == 2'h3 && CHIP_MODE == 3'h0
    |=> MODE_STATUS == 2'h3)
    else $error("normal lost");
  AST_REFUSED: assert property (
    CE && MODE_WR && ((MODE_CODE == 2'h3 && CHIP_MODE inside {3'h1, 3'h2,
    3'h3}) || (MODE_CODE == 2'h2 && CHIP_MODE inside {3'h2, 3'h3}))
    |=> $stable(MODE_STATUS))
    else $error("illegal mode accepted");
  AST_DRIVE_FROM_LOW: assert property (
    BUS_DRIVE_DOM |-> !$past(BUS_TX_INPUT))
    else $error("dominant without low input");
  AST_DRIVE_HOLDS: assert property (
    CE && !MODE_WR && BUS_DRIVE_DOM && !BUS_TX_INPUT |=> BUS_DRIVE_DOM)
    else $error("dominant dropped");
  AST_ENABLE_DELAY: assert property (
    en_reg <= EN_CYC |-> !BUS_DRIVE_DOM)
    else $error("drive inside enabling delay");
  AST_DRIVER_OFF: assert property (
    $past(MODE_STATUS) != 2'h3 |-> !BUS_DRIVE_DOM)
    else $error("drive outside normal");
  AST_RX_FOLLOWS: assert property (
    CE && MODE_STATUS[1] |=> BUS_RX_OUTPUT == $past(BUS_RX_LEVEL))
    else $error("receive lag");
  AST_WAKE_PATTERN: assert property (
    WAKE_EVENT |-> dom_reg >= WAKE1_CYC)
    else $error("wake without long dominant");
  AST_WAKE_MARK: assert property (
    WAKE_EVENT |-> MODE_STATUS == 2'h1 ##1 !BUS_RX_OUTPUT)
    else $error("wake not marked");
  AST_WAKE_STAYS: assert property (
    MODE_STATUS == 2'h1 && !BUS_RX_OUTPUT && !MODE_WR |=> !BUS_RX_OUTPUT)
    else $error("wake mark lost");
  // Main scenarios reached
  cover property (WAKE_EVENT);
  cover property (BUS_DRIVE_DOM);
  cover property (MODE_STATUS == 2'h2);
endmodule // cantrx_assertions
bind cantrx_top cantrx_assertions #(.EN_CYC(EN_CYC), .WAKE1_CYC(WAKE1_CYC))
  cantrx_assertions_inst (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
  .MODE_WR(MODE_WR), .MODE_CODE(MODE_CODE), .CHIP_MODE(CHIP_MODE),
  .BUS_TX_INPUT(BUS_TX_INPUT), .BUS_RX_LEVEL(BUS_RX_LEVEL),
  .BUS_DRIVE_DOM(BUS_DRIVE_DOM), .BUS_RX_OUTPUT(BUS_RX_OUTPUT),
  .MODE_STATUS(MODE_STATUS), .WAKE_EVENT(WAKE_EVENT));
`default_nettype wire

// ---- cantrx_ctrl_model.sv ----
// Protocol controller model driving the transmit input.
// Assumes start pulses with each normal mode request.
`timescale 1ns/100ps
`default_nettype none
module cantrx_ctrl_model
#(
  parameter int EN_CYC = 4
) (
  input wire logic clk,
  input wire logic start, // Normal mode requested now
  input wire logic rude, // Ignore the hold-off on purpose
  input wire logic dom_req, // Wanted bit, high is dominant
  output var logic tx // Transmit level, low is dominant
);
  int wait_cnt = 0; // Hold-off cycles left, with two of margin
  initial tx = 1'b1;
  // Recessive until the enabling delay is over
  always @(posedge clk)
  begin
    wait_cnt <= start ? EN_CYC + 2 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
    tx <= #1 (wait_cnt > 0 && !rude) ? 1'b1 : !dom_req;
  end
endmodule // cantrx_ctrl_model
`default_nettype wire

// ---- cantrx_top_test.sv ----
// Self-checking bench for the transceiver mode control block.
// Assumes small delay parameters and the controller model beside it.
`timescale 1ns/100ps
`default_nettype none
module cantrx_top_test;
  import cantrx_pkg::*;
  logic CLK = 0, RESET_N = 0, CE = 1, MODE_WR = 0; // Clock and controls
  logic [1:0] MODE_CODE = 2'h0; // Requested mode
  logic [2:0] CHIP_MODE = 3'h0; // Chip operating mode
  logic BUS_RX_LEVEL = 1, SAMPLE_READY = 0; // Bus level and sink
  logic start = 0, rude = 0, dom_req = 0, chk_smp = 0; // Model control
  logic BUS_TX_INPUT, BUS_DRIVE_DOM, BUS_RX_OUTPUT, WAKE_EVENT;
  logic SAMPLE_VALID, SAMPLE_DATA;
  logic [1:0] MODE_STATUS;
  int n_errors = 0, total_checks = 0, i; // Counters
  logic q_smp[$]; // Expected sample words
  logic [1:0] q_wake[$]; // Expected mode at each wake
  cantrx_top #(.EN_CYC(4), .WAKE1_CYC(3), .WAKE2_CYC(50)) cantrx_top_inst (
    .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .MODE_WR(MODE_WR),
    .MODE_CODE(MODE_CODE), .CHIP_MODE(CHIP_MODE),
    .BUS_TX_INPUT(BUS_TX_INPUT), .BUS_RX_LEVEL(BUS_RX_LEVEL),
    .SAMPLE_READY(SAMPLE_READY), .BUS_DRIVE_DOM(BUS_DRIVE_DOM),
    .BUS_RX_OUTPUT(BUS_RX_OUTPUT), .MODE_STATUS(MODE_STATUS),
    .WAKE_EVENT(WAKE_EVENT), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_DATA(SAMPLE_DATA));
  // Controller model; its default hold-off matches EN_CYC above
  cantrx_ctrl_model cantrx_ctrl_model_inst (.clk(CLK),
    .start(start), .rude(rude), .dom_req(dom_req), .tx(BUS_TX_INPUT));
  always #12.5 CLK = ~CLK;
  // Value comparison, four-state exact
  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wake result against the oldest wake note
  task automatic check_wake(input logic [1:0] got);
    logic [1:0] want;
    want = q_wake.size() ? q_wake.pop_front() : 2'hx;
    check(got, want);
  endtask
  // Sample result against the oldest sample note
  task automatic check_sample(input logic got);
    logic want;
    want = q_smp.size() ? q_smp.pop_front() : 1'bx;
    check({1'b0, got}, {1'b0, want});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // One-cycle mode command, then one settle cycle
  task automatic set_mode(input logic [1:0] code, input logic [2:0] chip);
    MODE_CODE = code;
    CHIP_MODE = chip;
    MODE_WR = 1;
    start = (code == 2'h3);
    tick(1);
    MODE_WR = 0;
    start = 0;
    tick(1);
  endtask
  // Dominant, recessive, dominant, each n cycles
  task automatic wake_pat(input int n);
    BUS_RX_LEVEL = 0;
    tick(n);
    BUS_RX_LEVEL = 1;
    tick(n);
    BUS_RX_LEVEL = 0;
    tick(n);
    BUS_RX_LEVEL = 1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Result watcher: each wake, and each sample while chk_smp is set, takes the oldest note
  always @(posedge CLK)
  begin
    if (WAKE_EVENT === 1'b1)
      check_wake(MODE_STATUS);
    if (chk_smp && SAMPLE_VALID === 1'b1 && SAMPLE_READY)
      check_sample(SAMPLE_DATA);
  end
  // Hang guard
  initial
  begin
    #2000000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'h71df));
    tick(16);
    RESET_N = 1;
    tick(1);
    check(MODE_STATUS, 2'h0);
    check({BUS_DRIVE_DOM, BUS_RX_OUTPUT}, 2'h1);
    CE = 0; // Frozen block must not take a command
    set_mode(2'h1, 3'h0);
    check(MODE_STATUS, 2'h0);
    CE = 1;
    dom_req = 1; // Low input and a wake pattern while off
    wake_pat(5);
    check({BUS_DRIVE_DOM, BUS_RX_OUTPUT}, 2'h1);
    set_mode(2'h3, 3'h1); // Normal refused in stop
    check(MODE_STATUS, 2'h0);
    set_mode(2'h2, 3'h2); // Receive-only refused in sleep
    check(MODE_STATUS, 2'h0);
    set_mode(2'h3, 3'h0);
    check({MODE_STATUS[0], BUS_DRIVE_DOM}, 2'h2);
    tick(8);
    for (i = 0; i < 20; i++)
    begin
      dom_req = 1'($urandom);
      BUS_RX_LEVEL = 1'($urandom);
      tick(2);
      check({1'b0, BUS_DRIVE_DOM}, {1'b0, dom_req});
      check({1'b0, BUS_RX_OUTPUT}, {1'b0, BUS_RX_LEVEL});
    end
    set_mode(2'h0, 3'h0); // Early low held across the delay
    BUS_RX_LEVEL = 1;
    rude = 1;
    dom_req = 1;
    set_mode(2'h3, 3'h0);
    tick(8);
    check({1'b0, BUS_DRIVE_DOM}, 2'h0);
    dom_req = 0;
    tick(2);
    dom_req = 1;
    rude = 0;
    tick(2);
    check({1'b0, BUS_DRIVE_DOM}, 2'h1);
    set_mode(2'h2, 3'h1); // Receive-only in stop, input still low
    check(MODE_STATUS, 2'h2);
    check({1'b0, BUS_DRIVE_DOM}, 2'h0);
    set_mode(2'h1, 3'h1); // Short pattern must not wake
    wake_pat(2);
    tick(5);
    check({1'b0, BUS_RX_OUTPUT}, 2'h1);
    q_wake.push_back(2'h1);
    wake_pat(6);
    for (i = 0; i < 40 && q_wake.size() > 0; i++)
      tick(1);
    check({1'b0, q_wake.size() == 0}, 2'h1);
    if (q_wake.size() > 0)
      stop_test();
    tick(5);
    check({MODE_STATUS[0], BUS_RX_OUTPUT}, 2'h2);
    set_mode(2'h0, 3'h0);
    check({1'b0, BUS_RX_OUTPUT}, 2'h1);
    CHIP_MODE = 3'h4; // Fail-safe forces the wake watch
    tick(2);
    check(MODE_STATUS, 2'h1);
    set_mode(2'h0, 3'h0); // Off is taken from any mode
    check(MODE_STATUS, 2'h0);
    SAMPLE_READY = 1; // Empty the sample buffer first
    tick(20);
    SAMPLE_READY = 0;
    BUS_RX_LEVEL = 0;
    set_mode(2'h2, 3'h0); // Fill past full with the sink stalled
    tick(30);
    set_mode(2'h0, 3'h0);
    BUS_RX_LEVEL = 1;
    // Sixteen in the buffer and one in the output register
    for (i = 0; i < CANTRX_FIFO_D + 1; i++)
      q_smp.push_back(1'b0);
    chk_smp = 1;
    SAMPLE_READY = 1;
    tick(30);
    check({1'b0, q_smp.size() == 0}, 2'h1);
    stop_test();
  end
endmodule // cantrx_top_test
`default_nettype wire
